// ### dv/testbench.sv
/*
  self-checking bench of the wake and power command block;
  assumes the design files under verilog/ are compiled first
*/
`include "wake_cmd_regs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [47:0] STA = 48'h0A1B_2C3D_4E5F;
  localparam logic [47:0] BC  = 48'hFFFF_FFFF_FFFF;

  logic        CLK_SYS = 1'b0;
  logic        SRST = 1'b1;
  logic        POR = 1'b1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        PWR_GOOD = 1'b1;
  logic        LINK_CHANGE = 1'b0;
  logic        RX_VALID = 1'b0;
  logic        RX_FIRST = 1'b0;
  logic        RX_LAST = 1'b0;
  logic [7:0]  RX_BYTE = 8'h00;
  logic        TAG_STROBE = 1'b0;
  logic        TAG_BIT = 1'b0;
  wire logic   RWU_IN;
  logic [31:0] RDATA;
  logic [15:0] DESC_TAG;
  logic        DESC_TAG_VALID;
  logic        WAKE_MODE;
  logic        PME;
  logic        RWU_OUT;
  logic        RWU_OE;
  logic        PHY_RESET_OUT;
  logic        IRQ;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          tag_cnt = 0;
  logic [15:0] tag_seen = 16'h0;
  logic [31:0] row_wd [8] = '{32'h0000_0081, 32'h0000_00FE, 32'h0000_0005, 32'h0000_8700,
                              32'h0000_0200, 32'h0000_7800, 32'h0000_007F, 32'h0000_0700};
  logic [31:0] row_ex [8] = '{32'h0000_0001, 32'h0000_007F, 32'h0000_007A, 32'h0000_077A,
                              32'h0000_057A, 32'h0000_057A, 32'h0000_0500, 32'h0000_0000};
  logic [47:0] fd [5] = '{STA, BC, BC, BC, STA};
  int          fn [5] = '{16, 16, 16, 16, 15};
  logic [3:0]  fc [5] = '{4'b1001, 4'b0000, 4'b0011, 4'b0101, 4'b0000};

  // pin level seen back: pulled up when nobody drives
  assign RWU_IN = RWU_OE ? RWU_OUT : 1'b1;

  always #2.5 CLK_SYS = ~CLK_SYS;

  wake_power_ctrl wake_power_ctrl_i (.CLK_SYS, .SRST, .POR, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .PWR_GOOD, .LINK_CHANGE, .RX_VALID, .RX_FIRST, .RX_LAST, .RX_BYTE, .TAG_STROBE,
    .TAG_BIT, .DESC_TAG, .DESC_TAG_VALID, .WAKE_MODE, .PME, .RWU_IN, .RWU_OUT, .RWU_OE,
    .PHY_RESET_OUT, .IRQ);

  ////////////////////////////////////////////////////////////////
  // tag monitor and hang guard
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (DESC_TAG_VALID === 1'b1) begin
      tag_cnt <= tag_cnt + 1;
      tag_seen <= DESC_TAG;
    end
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : cyc

  // bus write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr

  // bus read, data taken in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string nm);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk32(nm, e, RDATA & m);
  endtask : rchk

  task automatic rst(input logic p);
    @(posedge CLK_SYS);
    SRST <= 1'b1;
    POR <= p;
    @(posedge CLK_SYS);
    SRST <= 1'b0;
    POR <= 1'b0;
  endtask : rst

  task automatic link;
    @(posedge CLK_SYS);
    LINK_CHANGE <= 1'b1;
    @(posedge CLK_SYS);
    LINK_CHANGE <= 1'b0;
  endtask : link

  // power good changes at a rising edge like every other input
  task automatic pg(input logic v);
    @(posedge CLK_SYS);
    PWR_GOOD <= v;
  endtask : pg

  // frame: destination, copies of the station address, pad byte; tag during body
  task automatic frame(input logic [47:0] dst, input int cp, input logic [15:0] tg);
    logic [7:0] b[$];
    for (int i = 0; i < 6; i++) b.push_back(dst[47-8*i -: 8]);
    for (int c = 0; c < cp; c++)
      for (int i = 0; i < 6; i++) b.push_back(STA[47-8*i -: 8]);
    b.push_back(8'h00);
    foreach (b[i]) begin
      @(posedge CLK_SYS);
      RX_VALID <= 1'b1;
      RX_FIRST <= (i == 0);
      RX_LAST <= (i == b.size() - 1);
      RX_BYTE <= b[i];
      TAG_STROBE <= (i >= 6 && i < 22);
      TAG_BIT <= (i >= 6 && i < 22) ? tg[21-i] : 1'b0;
    end
    @(posedge CLK_SYS);
    RX_VALID <= 1'b0;
    RX_LAST <= 1'b0;
    TAG_STROBE <= 1'b0;
  endtask : frame

  ////////////////////////////////////////////////////////////////
  initial begin
    logic oe;
    int   n;
    repeat (10) @(posedge CLK_SYS);
    SRST <= 1'b0;
    POR <= 1'b0;
    // reset values and unmapped place
    rchk(`OFS_WAKE_POWER_CMD, 32'h0, 32'h0000_077F, "cmd");
    rchk(`OFS_SOFTWARE_WAKE, 32'h0, 32'h7, "sw");
    chk1("phy_reset_out", 1'b0, PHY_RESET_OUT);
    chk1("rwu_oe", 1'b0, RWU_OE);
    wr(8'hF0, 32'hFFFF_FFFF);
    rchk(8'hF0, 32'h0, 32'hFFFF_FFFF, "unmapped");
    $display("test reset done");
    // masked command writes from the table
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_WAKE_POWER_CMD, row_wd[i]);
      rchk(`OFS_WAKE_POWER_CMD, row_ex[i], 32'h0000_077F, "cmd");
    end
    $display("test masks done");
    // sticky twins survive hardware reset
    wr(`OFS_SOFTWARE_WAKE, 32'h0000_0087);
    rst(1'b0);
    rchk(`OFS_SOFTWARE_WAKE, 32'h7, 32'h7, "sw");
    cyc(2);
    chk1("wake", 1'b1, WAKE_MODE);
    rst(1'b1);
    rchk(`OFS_SOFTWARE_WAKE, 32'h0, 32'h7, "sw");
    // pin enable waits for power good low
    wr(`OFS_WAKE_POWER_CMD, 32'h0000_8100);
    cyc(3);
    chk1("wake", 1'b0, WAKE_MODE);
    pg(1'b0);
    cyc(3);
    chk1("wake", 1'b1, WAKE_MODE);
    rst(1'b0);
    cyc(3);
    chk1("wake", 1'b0, WAKE_MODE);
    pg(1'b1);
    $display("test wake done");
    // link change, event output and interrupt
    link();
    rchk(`OFS_IRQ_STATUS, 32'h0, 32'h3, "status");
    wr(`OFS_WAKE_POWER_CMD, 32'h0000_00A0);
    link();
    rchk(`OFS_IRQ_STATUS, 32'h2, 32'h3, "status");
    chk1("irq", 1'b0, IRQ);
    chk1("pme", 1'b0, PME);
    wr(`OFS_WAKE_POWER_CMD, 32'h0000_0090);
    cyc(2);
    chk1("pme", 1'b1, PME);
    wr(`OFS_IRQ_MASK, 32'h2);
    cyc(2);
    chk1("irq", 1'b1, IRQ);
    wr(`OFS_IRQ_MASK, 32'h0);
    // remote wake pin over drive type, gate, polarity and power good
    for (int f = 1; f >= 0; f--) begin
      for (int k = 0; k < 16; k++) begin
        pg(k[3]);
        wr(`OFS_WAKE_POWER_CMD, 32'h0000_000E);
        wr(`OFS_WAKE_POWER_CMD, {24'h0, 1'b1, 3'b000, k[2:0], 1'b0});
        cyc(2);
        oe = k[2] ? 1'b1 : f[0];
        if (k[1] && !k[3]) oe = 1'b0;
        chk1("rwu_oe", oe, RWU_OE);
        if (oe) chk1("rwu_out", f[0] ^ k[0], RWU_OUT);
        rchk(`OFS_WAKE_CFG, {28'h0, ~oe | (f[0] ^ k[0]), 3'h0}, 32'h8, "rwu_in");
      end
      wr(`OFS_IRQ_STATUS, 32'h3);
      rchk(`OFS_IRQ_STATUS, 32'h0, 32'h3, "status");
      chk1("irq", 1'b0, IRQ);
    end
    pg(1'b1);
    // PHY reset pin polarity
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_WAKE_POWER_CMD, {24'h0, k[0], 7'h01});
      wr(`OFS_WAKE_CFG, {29'h0, k[1], 2'b00});
      cyc(2);
      chk1("phy_reset_out", k[1] ^ k[0], PHY_RESET_OUT);
    end
    wr(`OFS_WAKE_CFG, 32'h0);
    $display("test pins done");
    // wake frames and tags
    wr(`OFS_SOFTWARE_WAKE, 32'h0000_0082);
    wr(`OFS_STATION_LO, STA[31:0]);
    wr(`OFS_STATION_HI, {16'h0, STA[47:32]});
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_WAKE_CFG, {31'h0, fc[i][1]});
      wr(`OFS_WAKE_POWER_CMD, 32'h0000_0600);
      wr(`OFS_WAKE_POWER_CMD, {16'h0, 1'b1, 4'h0, fc[i][3:2], 9'h000});
      n = tag_cnt;
      frame(fd[i], fn[i], 16'hA5C3);
      cyc(4);
      rchk(`OFS_IRQ_STATUS, {31'h0, fc[i][0]}, 32'h1, "match");
      chk1("tag_valid", fc[i][3], tag_cnt != n);
      if (fc[i][3]) chk32("tag", 32'h0000_A5C3, {16'h0, tag_seen});
      wr(`OFS_IRQ_STATUS, 32'h1);
    end
    $display("test frames done");
    stop_test();
  end
endmodule : testbench

`default_nettype wire

// ### verilog/frame_tag_capture.sv
/*
  shifts in serial tag bits while a frame is received and hands the tag to
  the descriptor writer at frame end; assumes tag strobes synchronous to clk
*/
`default_nettype none

module frame_tag_capture #(
  parameter int TAG_W = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             enable,
  input  wire logic             rx_first,
  input  wire logic             rx_last,
  input  wire logic             tag_strobe,
  input  wire logic             tag_bit,
  output logic [TAG_W-1:0]      tag_word,
  output logic                  tag_valid
);
  logic [TAG_W-1:0] shift_q;
  logic             in_frame_q;

  if (TAG_W < 2 || TAG_W > 32) begin : g_chk
    $error("TAG_W must be 2..32");
  end

  // frame window and shifter
  always_ff @(posedge clk) begin
    if (srst) begin
      in_frame_q <= 1'b0;
      shift_q    <= '0;
    end else begin
      if (rx_first) begin
        in_frame_q <= 1'b1;
        shift_q    <= {{(TAG_W-1){1'b0}}, tag_strobe & tag_bit};
      end else if (rx_last) begin
        in_frame_q <= 1'b0;
      end
      if (tag_strobe && in_frame_q && !rx_first) begin
        shift_q <= {shift_q[TAG_W-2:0], tag_bit};
      end
    end
  end

  // copy into the descriptor at frame end
  always_ff @(posedge clk) begin
    if (srst) begin
      tag_word  <= '0;
      tag_valid <= 1'b0;
    end else begin
      tag_valid <= enable & rx_last & in_frame_q;
      if (enable && rx_last && in_frame_q) begin
        tag_word <= shift_q;
      end
    end
  end
endmodule : frame_tag_capture

`default_nettype wire

// ### verilog/wake_cmd_pkg.sv
/*
  types shared by the wake-up command block and its frame matcher;
  assumes nothing of its surroundings
*/
`default_nettype none

package wake_cmd_pkg;
  // wake frame scanner states
  typedef enum logic [1:0] {
    ST_DEST = 2'b00,
    ST_BODY = 2'b01,
    ST_SKIP = 2'b10
  } scan_state_t;
endpackage : wake_cmd_pkg

`default_nettype wire

// ### verilog/wake_cmd_regs.svh
/*
  register offsets, field positions, reset values and frame shape counts of the
  wake-up and power command block; assumes a 32-bit byte-addressed port
*/
`ifndef WAKE_CMD_REGS_SVH
`define WAKE_CMD_REGS_SVH

// byte offsets
`define OFS_WAKE_POWER_CMD   8'h50
`define OFS_SOFTWARE_WAKE    8'h64
`define OFS_IRQ_STATUS       8'h70
`define OFS_IRQ_MASK         8'h74
`define OFS_WAKE_CFG         8'h78
`define OFS_STATION_LO       8'h7C
`define OFS_STATION_HI       8'h80

// wake_power_command fields
`define CMD_TAG_EN           10
`define CMD_ANY_DEST         9
`define CMD_PIN_EN           8
`define CMD_BYTE1_VALUE_BIT             15
`define CMD_BYTE0_VALUE_BIT             7
`define CMD_MODE_EN          6
`define CMD_LINK_EN          5
`define CMD_PME_OVR          4
`define CMD_RWU_DRIVE        3
`define CMD_REMOTE_WAKE_GATE         2
`define CMD_REMOTE_WAKE_POLARITY          1
`define CMD_PHY_POL          0
`define CMD_RESET            11'h000

// software_wake_command fields
`define SW_PIN_EN            2
`define SW_MODE_EN           1
`define SW_LINK_EN           0

// status / mask fields
`define IRQ_MATCH            0
`define IRQ_LINK             1

// wake_cfg fields
`define CFG_EXT_ANY_DEST     0
`define CFG_PME_ENABLE           1
`define CFG_PHY_RESET        2
`define CFG_PIN_LEVEL        3

// magic frame shape
`define ADDR_BYTES           6
`define ADDR_COPIES          16

`endif

// ### verilog/wake_frame_matcher.sv
/*
  scans a received byte stream for a wake frame: destination check, then
  sixteen back-to-back copies of the station address anywhere in the body;
  assumes bytes arrive synchronous to clk with a first-byte and last-byte flag
*/
`include "wake_cmd_regs.svh"
`default_nettype none

module wake_frame_matcher (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        rx_valid,
  input  wire logic        rx_first,
  input  wire logic        rx_last,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [47:0] station_addr,
  input  wire logic        any_dest,
  output logic             match_pulse
);
  import wake_cmd_pkg::*;

  scan_state_t state_q;
  logic [2:0]  idx_q;
  logic [4:0]  copies_q;
  logic        dest_ok_q;
  logic        found_q;
  logic [7:0]  want;
  logic [7:0]  want_first;
  logic        hit;
  logic [2:0]  pos;

  // expected address byte, most significant byte goes first on the wire
  always_comb begin
    pos = rx_first ? 3'h0 : idx_q; // a new frame always starts at byte 0
    want = station_addr[8*(5-pos) +: 8];
    want_first = station_addr[47:40];
    hit = (rx_byte == want);
  end

  // destination and body scan
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= ST_DEST;
      idx_q     <= 3'h0;
      copies_q  <= 5'h00;
      dest_ok_q <= 1'b0;
      found_q   <= 1'b0;
    end else if (rx_valid) begin
      if (rx_first) begin
        state_q   <= ST_DEST;
        idx_q     <= 3'h1;
        copies_q  <= 5'h00;
        found_q   <= 1'b0;
        dest_ok_q <= any_dest | hit;
      end else begin
        unique case (state_q)
          ST_DEST: begin
            dest_ok_q <= dest_ok_q & (any_dest | hit);
            if (idx_q == 3'(`ADDR_BYTES - 1)) begin
              state_q <= ST_BODY;
              idx_q   <= 3'h0;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
          ST_BODY: begin
            if (hit) begin
              if (idx_q == 3'(`ADDR_BYTES - 1)) begin
                idx_q    <= 3'h0;
                copies_q <= copies_q + 5'h01;
                if (copies_q == 5'(`ADDR_COPIES - 1)) begin
                  found_q <= 1'b1;
                  state_q <= ST_SKIP;
                end
              end else begin
                idx_q <= idx_q + 3'h1;
              end
            end else begin
              // restart, this byte may open a new run
              copies_q <= 5'h00;
              idx_q    <= (rx_byte == want_first) ? 3'h1 : 3'h0;
            end
          end
          ST_SKIP: begin
            state_q <= ST_SKIP;
          end
          default: begin
            state_q <= ST_DEST;
          end
        endcase
      end
    end
  end

  // one pulse at the last byte of a qualifying frame
  always_ff @(posedge clk) begin
    if (srst) begin
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= rx_valid & rx_last & found_q & dest_ok_q;
    end
  end
endmodule : wake_frame_matcher

`default_nettype wire

// ### verilog/wake_power_ctrl.sv
/*
  wake-up and power command registers with their effect on wake mode,
  the power management event, the remote wake pin and the PHY reset pin;
  assumes a single 200 MHz clock, synchronous inputs, SRST as hardware
  reset and POR as the power-on reset that alone clears the sticky twins
*/
// Chosen here: the strobed register port and the address map.
`include "wake_cmd_regs.svh"
`default_nettype none

// Contract
// - with the tag enable bit set, tag bits shifted in during a frame are copied to its descriptor.
// - with the accept bit clear a wake frame needs the station address as destination, else any.
// - a wake frame must carry sixteen consecutive copies of the full station address.
// - the effective accept setting is the OR of the accept bit and the extended accept bit.
// - if either pin enable bit is set, wake mode is entered when power good goes low.
// - if either mode enable bit is set, wake mode is entered regardless of power good.
// - hardware reset clears the resettable enable bits and leaves their sticky twins.
// - a write loads value bit 7 into each of bits 6..0 whose mask bit is one.
// - a write loads value bit 15 into each of bits 10..8 whose mask bit is one.
// - with either link wake bit set, a link change sets the link change flag.
// - with override set and a flag set, the event output asserts whatever the enable says.
// - bit 3 set drives the remote wake pin both ways, clear only pulls to the asserted level.
// - bit 2 set floats the remote wake pin while power good is low.
// - bit 1 set makes the remote wake pin idle high and assert low, clear the reverse.
// - bit 0 set makes the PHY reset output active low, clear active high.
module wake_power_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        POR,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  input  wire logic        PWR_GOOD,
  input  wire logic        LINK_CHANGE,
  input  wire logic        RX_VALID,
  input  wire logic        RX_FIRST,
  input  wire logic        RX_LAST,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        TAG_STROBE,
  input  wire logic        TAG_BIT,
  output logic [15:0]      DESC_TAG,
  output logic             DESC_TAG_VALID,
  output logic             WAKE_MODE,
  output logic             PME,
  input  wire logic        RWU_IN,
  output logic             RWU_OUT,
  output logic             RWU_OE,
  output logic             PHY_RESET_OUT,
  output logic             IRQ
);
  import wake_cmd_pkg::*;

  logic [10:0] cmd_q;
  logic [10:0] cmd_d;
  logic [2:0]  sw_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic [2:0]  cfg_q;
  logic [47:0] station_q;
  logic        match_pulse;
  logic        wake_mode_d;
  logic        link_en;
  logic        any_dest;
  logic        flags;
  logic        rwu_assert;
  logic [1:0]  status_set;
  logic [1:0]  status_clr;
  logic        wr_cmd;
  logic        wr_sw;
  logic [15:0] tag_word;
  logic        tag_valid;
  logic        srst_late_q;

  ////////////////////////////////////////////////////////////////////////
  // command register writes

  assign wr_cmd = WR && (ADDR == `OFS_WAKE_POWER_CMD);
  assign wr_sw  = WR && (ADDR == `OFS_SOFTWARE_WAKE);

  // masked byte writes, mask zero leaves a bit alone
  always_comb begin
    cmd_d = cmd_q;
    for (int i = 0; i <= `CMD_MODE_EN; i++) begin
      if (WDATA[i]) begin
        cmd_d[i] = WDATA[`CMD_BYTE0_VALUE_BIT];
      end
    end
    for (int i = `CMD_PIN_EN; i <= `CMD_TAG_EN; i++) begin
      if (WDATA[i]) begin
        cmd_d[i] = WDATA[`CMD_BYTE1_VALUE_BIT];
      end
    end
  end

  // bit 7 of the field is the value slot and always reads zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      cmd_q <= `CMD_RESET;
    end else if (wr_cmd) begin
      cmd_q <= {cmd_d[10:8], 1'b0, cmd_d[6:0]};
    end
  end

  // sticky twins, untouched by hardware reset
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      sw_q <= 3'h0;
    end else if (wr_sw) begin
      for (int i = 0; i <= `SW_PIN_EN; i++) begin
        if (WDATA[i]) begin
          sw_q[i] <= WDATA[`CMD_BYTE0_VALUE_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // other software registers

  // mask, configuration and station address
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      mask_q    <= 2'h0;
      cfg_q     <= 3'h0;
      station_q <= 48'h0000_0000_0000;
    end else if (WR) begin
      if (ADDR == `OFS_IRQ_MASK) begin
        mask_q <= WDATA[1:0];
      end
      if (ADDR == `OFS_WAKE_CFG) begin
        cfg_q <= WDATA[2:0];
      end
      if (ADDR == `OFS_STATION_LO) begin
        station_q[31:0] <= WDATA;
      end
      if (ADDR == `OFS_STATION_HI) begin
        station_q[47:32] <= WDATA[15:0];
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        `OFS_WAKE_POWER_CMD: RDATA <= {21'h000000, cmd_q};
        `OFS_SOFTWARE_WAKE:  RDATA <= {29'h00000000, sw_q};
        `OFS_IRQ_STATUS:     RDATA <= {30'h00000000, status_q};
        `OFS_IRQ_MASK:       RDATA <= {30'h00000000, mask_q};
        `OFS_WAKE_CFG:       RDATA <= {28'h0000000, RWU_IN, cfg_q};
        `OFS_STATION_LO:     RDATA <= station_q[31:0];
        `OFS_STATION_HI:     RDATA <= {16'h0000, station_q[47:32]};
        default:             RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake mode, frame matching and frame tags

  assign any_dest = cmd_q[`CMD_ANY_DEST] | cfg_q[`CFG_EXT_ANY_DEST];
  assign link_en  = cmd_q[`CMD_LINK_EN] | sw_q[`SW_LINK_EN];

  // software entry or loss of power good with a pin enable
  assign wake_mode_d = cmd_q[`CMD_MODE_EN] | sw_q[`SW_MODE_EN]
                     | ((cmd_q[`CMD_PIN_EN] | sw_q[`SW_PIN_EN]) & ~PWR_GOOD);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WAKE_MODE <= 1'b0;
    end else begin
      WAKE_MODE <= wake_mode_d;
    end
  end

  // wake frame scanner, destination check then address copies
  wake_frame_matcher u_matcher (
    .clk          (CLK_SYS),
    .srst         (SRST),
    .rx_valid     (RX_VALID),
    .rx_first     (RX_FIRST),
    .rx_last      (RX_LAST),
    .rx_byte      (RX_BYTE),
    .station_addr (station_q),
    .any_dest     (any_dest),
    .match_pulse  (match_pulse)
  );

  // tag shifter framed by the same byte flags as the scanner
  frame_tag_capture #(
    .TAG_W (16)
  ) u_tag (
    .clk        (CLK_SYS),
    .srst       (SRST),
    .enable     (cmd_q[`CMD_TAG_EN]),
    .rx_first   (RX_VALID & RX_FIRST),
    .rx_last    (RX_VALID & RX_LAST),
    .tag_strobe (TAG_STROBE),
    .tag_bit    (TAG_BIT),
    .tag_word   (tag_word),
    .tag_valid  (tag_valid)
  );

  // descriptor tag handed out one cycle after capture
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      DESC_TAG       <= 16'h0000;
      DESC_TAG_VALID <= 1'b0;
    end else begin
      DESC_TAG       <= tag_word;
      DESC_TAG_VALID <= tag_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags and interrupt

  assign status_set = {LINK_CHANGE & link_en, match_pulse & WAKE_MODE};
  assign status_clr = (WR && ADDR == `OFS_IRQ_STATUS) ? WDATA[1:0] : 2'h0;

  // sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // level interrupt, a set mask bit lets its flag through
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event, remote wake and PHY reset pins

  assign flags      = |status_q;
  assign rwu_assert = flags & ~(cmd_q[`CMD_REMOTE_WAKE_GATE] & ~PWR_GOOD);

  // registered pins, the gate overrides both driver types
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PME           <= 1'b0;
      RWU_OUT       <= 1'b0;
      RWU_OE        <= 1'b0;
      PHY_RESET_OUT <= 1'b0;
    end else begin
      PME <= flags & (cfg_q[`CFG_PME_ENABLE] | cmd_q[`CMD_PME_OVR]);
      RWU_OUT <= rwu_assert ^ cmd_q[`CMD_REMOTE_WAKE_POLARITY];
      if (cmd_q[`CMD_REMOTE_WAKE_GATE] && !PWR_GOOD) begin
        RWU_OE <= 1'b0;
      end else begin
        RWU_OE <= cmd_q[`CMD_RWU_DRIVE] | rwu_assert;
      end
      PHY_RESET_OUT <= cfg_q[`CFG_PHY_RESET] ^ cmd_q[`CMD_PHY_POL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // reset shadow, keeps checks off the edge right after a reset edge
  always_ff @(posedge CLK_SYS) begin
    srst_late_q <= SRST;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST || srst_late_q);

  // register writes, reset, wake entry, link flag, event override and pins
  masked_low_a: assert property (
    wr_cmd && WDATA[0] |=> cmd_q[0] == $past(WDATA[7]))
    else $error("masked write missed bit 0");
  masked_keep_a: assert property (
    wr_cmd && !WDATA[5] |=> cmd_q[5] == $past(cmd_q[5]))
    else $error("unmasked bit changed");
  masked_high_a: assert property (
    wr_cmd && WDATA[10] |=> cmd_q[10] == $past(WDATA[15]))
    else $error("byte 1 write missed bit 10");
  reset_clear_a: assert property (
    disable iff (POR) SRST && !POR |=> cmd_q == 11'h000 && sw_q == $past(sw_q))
    else $error("hardware reset handled wrong");
  pin_wake_a: assert property (
    (cmd_q[8] | sw_q[2]) && !PWR_GOOD |=> WAKE_MODE)
    else $error("no wake mode on power loss");
  sw_wake_a: assert property (
    sw_q[1] || cmd_q[6] |=> WAKE_MODE)
    else $error("no wake mode on enable");
  link_flag_a: assert property (
    LINK_CHANGE && link_en |=> status_q[1] ##1 (status_q[1] || $past(status_clr[1])))
    else $error("link change flag lost");
  pme_ovr_a: assert property (
    cmd_q[4] && flags |=> PME)
    else $error("override did not raise event");
  gate_float_a: assert property (
    cmd_q[2] && !PWR_GOOD |=> !RWU_OE)
    else $error("gated pin still driven");
  pole_drive_a: assert property (
    cmd_q[3] && !(cmd_q[2] && !PWR_GOOD) |=> RWU_OE)
    else $error("totem pin not driven");
  phy_pol_a: assert property (
    ##1 PHY_RESET_OUT == ($past(cfg_q[2]) ^ $past(cmd_q[0])))
    else $error("phy reset level wrong");

  // flags, event output, remote wake levels and tags
  set_wins_a: assert property (
    status_set[1] |=> status_q[1])
    else $error("link flag lost to a clear");
  match_flag_a: assert property (
    match_pulse && WAKE_MODE |=> status_q[0])
    else $error("wake frame flag not set");
  pme_quiet_a: assert property (
    !flags |=> !PME)
    else $error("event output without a flag");
  drain_release_a: assert property (
    !cmd_q[3] && !rwu_assert |=> !RWU_OE)
    else $error("open drain pin driven while idle");
  idle_level_a: assert property (
    cmd_q[3] && !rwu_assert |=> RWU_OUT == $past(cmd_q[1]))
    else $error("remote wake idle level wrong");
  assert_level_a: assert property (
    rwu_assert |=> RWU_OE && RWU_OUT == !$past(cmd_q[1]))
    else $error("remote wake asserted level wrong");
  tag_gate_a: assert property (
    DESC_TAG_VALID |-> $past(cmd_q[10], 2))
    else $error("tag handed out while disabled");
endmodule : wake_power_ctrl

`default_nettype wire
